// ===== inc/psg_map.vh
// Register map, field positions and timing constants of the sound core
`ifndef PSG_MAP_VH
`define PSG_MAP_VH

// Register indices on the four-bit register address
`define PSG_REG_TONE_LAST 4'h5
`define PSG_REG_NOISE_PERIOD 4'h6
`define PSG_REG_MIXER 4'h7
`define PSG_REG_VOL_A 4'h8
`define PSG_REG_VOL_B 4'h9
`define PSG_REG_VOL_C 4'ha
`define PSG_REG_ENV_FINE 4'hb
`define PSG_REG_ENV_COARSE 4'hc
`define PSG_REG_ENV_SHAPE 4'hd
`define PSG_REG_PORT_A 4'he
`define PSG_REG_PORT_B 4'hf

// Reset value of every register held here
`define PSG_RESET_BYTE 8'h00

// Mixer register fields
`define PSG_MIX_TONE_A 0
`define PSG_MIX_TONE_B 1
`define PSG_MIX_TONE_C 2
`define PSG_MIX_NOISE_A 3
`define PSG_MIX_NOISE_B 4
`define PSG_MIX_NOISE_C 5
`define PSG_MIX_DIR_A 6
`define PSG_MIX_DIR_B 7

// Volume register fields
`define PSG_VOL_SOURCE_BIT 4
`define PSG_VOL_LEVEL_HI 3

// Envelope shape fields
`define PSG_SHP_STOP 0
`define PSG_SHP_REVERSE 1
`define PSG_SHP_UP 2
`define PSG_SHP_REPEAT 3

// Bus modes after decoding the three control pins
`define PSG_MODE_IDLE 2'h0
`define PSG_MODE_ADDR 2'h1
`define PSG_MODE_READ 2'h2
`define PSG_MODE_WRITE 2'h3

// Upper address that selects this chip
`define PSG_CS_UPPER 4'h0

// Prescalers: noise divides by 16, envelope step by 256/32 = 8
`define PSG_NOISE_PRE_MAX 4'hf
`define PSG_ENV_PRE_MAX 3'h7
`define PSG_ENV_TOP 5'h1f

// Noise shift register: length, seed and feedback tap
`define PSG_LFSR_SEED 17'h00001
`define PSG_LFSR_TAP 3

`endif

// ===== hw/psg_env.v
// Envelope period divider and five-bit shape counter
`timescale 1ns/100ps
`default_nettype none
`include "psg_map.vh"

module psg_env (
    // Clock and reset
    input wire clk_in,
    input wire reset_n_in,
    // Settings from the register file
    input wire [15:0] period_in,
    input wire [3:0] shape_in,
    input wire restart_in,
    // Envelope level
    output reg [4:0] level_out
);

    reg [2:0] pre_q;
    reg [15:0] per_q;
    reg [4:0] cnt_q;
    reg up_q;
    reg hold_q;
    reg zero_q;
    wire pre_tick;
    wire [15:0] per_lim;
    wire step;

    // A period of zero behaves as one so the counter never stalls
    assign per_lim = (period_in == 16'h0000) ? 16'h0001 : period_in;
    assign pre_tick = (pre_q == `PSG_ENV_PRE_MAX);
    // Step period is 8 * period clocks: 32 steps per repeat of 256 * period
    assign step = pre_tick && (per_q >= per_lim - 16'h0001);

    always @(posedge clk_in) begin
        if (!reset_n_in || restart_in) begin
            pre_q <= 3'h0;
            per_q <= 16'h0000;
            cnt_q <= 5'h00;
            up_q <= shape_in[`PSG_SHP_UP];
            hold_q <= 1'b0;
            zero_q <= 1'b0;
            level_out <= 5'h00;
        end else begin
            pre_q <= pre_q + 3'h1;
            if (pre_tick) begin
                per_q <= step ? 16'h0000 : per_q + 16'h0001;
            end
            if (step && !hold_q && !zero_q) begin
                if (cnt_q != `PSG_ENV_TOP) begin
                    cnt_q <= cnt_q + 5'h01;
                end else if (!shape_in[`PSG_SHP_REPEAT]) begin
                    zero_q <= 1'b1;
                end else if (shape_in[`PSG_SHP_STOP]) begin
                    hold_q <= 1'b1;
                    if (shape_in[`PSG_SHP_REVERSE]) begin
                        up_q <= ~up_q;
                    end
                end else begin
                    cnt_q <= 5'h00;
                    if (shape_in[`PSG_SHP_REVERSE]) begin
                        up_q <= ~up_q;
                    end
                end
            end
            level_out <= zero_q ? 5'h00 : (up_q ? cnt_q : ~cnt_q);
        end
    end

endmodule // psg_env
`default_nettype wire

// ===== hw/psg_core.v
// Sound core: bus port, registers, noise, mixer, volume and ports
//
// Functional notes
// - Noise steps at clock / (16 * period).
// - Mixer bits 5..0: zero passes source.
// - Both zero mixes; both one silences.
// - Bits 7,6 set port directions, one outputs.
// - Volume mode bit picks fixed or envelope.
// - Fixed mode uses sixteen rewritable levels.
// - Envelope mode uses five-bit envelope level.
// - Envelope repeat is clock / (256 * period).
// - Step period is one thirty-second repeat.
// - Five-bit counter steps 32 per cycle.
// - Shape bits choose direction, stop, repeat.
// - Port registers hold host output data.
// - Reads leave sound generation undisturbed.
`timescale 1ns/100ps
`default_nettype none
`include "psg_map.vh"

module psg_core (
    // Clock and reset
    input wire clk_in,
    input wire reset_n_in,
    // Bus control pins
    input wire bdir_in,
    input wire bc2_in,
    input wire bc1_in,
    input wire a9_n_in,
    input wire a8_in,
    // Data bus pins
    input wire [7:0] da_in,
    output reg [7:0] da_out,
    output reg da_oe_out,
    // General purpose port pins
    input wire [7:0] port_a_in,
    output reg [7:0] port_a_out,
    output reg [7:0] port_a_oe_out,
    input wire [7:0] port_b_in,
    output reg [7:0] port_b_out,
    output reg [7:0] port_b_oe_out,
    // Square waves from the tone dividers
    input wire tone_a_in,
    input wire tone_b_in,
    input wire tone_c_in,
    // Write strobe toward the tone dividers
    output reg tone_wr_out,
    output reg [3:0] tone_addr_out,
    output reg [7:0] tone_data_out,
    // Channel levels toward the converters
    output reg [4:0] chan_a_level_out,
    output reg [4:0] chan_b_level_out,
    output reg [4:0] chan_c_level_out
);

    // Decode of the three bus control pins
    function [1:0] psg_mode;
        input bdir;
        input bc2;
        input bc1;
        begin
            case ({bdir, bc2, bc1})
                3'h1: psg_mode = `PSG_MODE_ADDR;
                3'h4: psg_mode = `PSG_MODE_ADDR;
                3'h7: psg_mode = `PSG_MODE_ADDR;
                3'h3: psg_mode = `PSG_MODE_READ;
                3'h6: psg_mode = `PSG_MODE_WRITE;
                default: psg_mode = `PSG_MODE_IDLE;
            endcase
        end
    endfunction

    // Mixer and volume select for one channel
    function [4:0] psg_chan;
        input tone;
        input noise;
        input tone_off;
        input noise_off;
        input [4:0] vol;
        input [4:0] env;
        reg gate;
        reg [3:0] fixed;
        begin
            gate = (tone | tone_off) & (noise | noise_off);
            fixed = vol[`PSG_VOL_LEVEL_HI:0];
            if ((tone_off && noise_off) || !gate) begin
                psg_chan = 5'h00;
            end else if (vol[`PSG_VOL_SOURCE_BIT]) begin
                psg_chan = env;
            end else if (fixed == 4'h0) begin
                psg_chan = 5'h00;
            end else begin
                psg_chan = {fixed, 1'b1};
            end
        end
    endfunction

    // Pin synchronisers: every pin passes two flip-flops
    reg [28:0] pin_s1_q;
    reg [28:0] pin_s2_q;
    wire [28:0] pin_raw;
    wire [1:0] mode;
    wire cs_ok;
    wire [7:0] da_s;
    wire [7:0] port_a_s;
    wire [7:0] port_b_s;

    assign pin_raw = {bdir_in, bc2_in, bc1_in, a9_n_in, a8_in, da_in,
                      port_a_in, port_b_in};

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            pin_s1_q <= 29'h00000000;
            pin_s2_q <= 29'h00000000;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end

    assign port_b_s = pin_s2_q[7:0];
    assign port_a_s = pin_s2_q[15:8];
    assign da_s = pin_s2_q[23:16];
    assign mode = psg_mode(pin_s2_q[28], pin_s2_q[27], pin_s2_q[26]);
    assign cs_ok = !pin_s2_q[25] && pin_s2_q[24] &&
                   (da_s[7:4] == `PSG_CS_UPPER);

    // Address latch and mode history
    reg [3:0] addr_q;
    reg sel_q;
    reg [1:0] mode_q;
    wire wr_go;

    // One write per entry into write mode, so a held strobe restarts
    // the envelope only once
    assign wr_go = (mode == `PSG_MODE_WRITE) &&
                   (mode_q != `PSG_MODE_WRITE) && sel_q;

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            addr_q <= 4'h0;
            sel_q <= 1'b0;
            mode_q <= `PSG_MODE_IDLE;
        end else begin
            mode_q <= mode;
            if (mode == `PSG_MODE_ADDR) begin
                sel_q <= cs_ok;
                if (cs_ok) begin
                    addr_q <= da_s[3:0];
                end
            end
        end
    end

    // Register file
    reg [4:0] noise_period_q;
    reg [7:0] mixer_q;
    reg [4:0] vol_a_q;
    reg [4:0] vol_b_q;
    reg [4:0] vol_c_q;
    reg [7:0] env_fine_q;
    reg [7:0] env_coarse_q;
    reg [3:0] env_shape_q;
    reg [7:0] port_a_q;
    reg [7:0] port_b_q;
    reg env_restart_q;
    // Narrow registers take only the low bits of the common reset byte
    localparam [7:0] RST_BYTE = `PSG_RESET_BYTE;

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            noise_period_q <= RST_BYTE[4:0];
            mixer_q <= `PSG_RESET_BYTE;
            vol_a_q <= RST_BYTE[4:0];
            vol_b_q <= RST_BYTE[4:0];
            vol_c_q <= RST_BYTE[4:0];
            env_fine_q <= `PSG_RESET_BYTE;
            env_coarse_q <= `PSG_RESET_BYTE;
            env_shape_q <= RST_BYTE[3:0];
            port_a_q <= `PSG_RESET_BYTE;
            port_b_q <= `PSG_RESET_BYTE;
            env_restart_q <= 1'b0;
        end else begin
            env_restart_q <= 1'b0;
            if (wr_go) begin
                case (addr_q)
                    `PSG_REG_NOISE_PERIOD: noise_period_q <= da_s[4:0];
                    `PSG_REG_MIXER: mixer_q <= da_s;
                    `PSG_REG_VOL_A: vol_a_q <= da_s[4:0];
                    `PSG_REG_VOL_B: vol_b_q <= da_s[4:0];
                    `PSG_REG_VOL_C: vol_c_q <= da_s[4:0];
                    `PSG_REG_ENV_FINE: env_fine_q <= da_s;
                    `PSG_REG_ENV_COARSE: env_coarse_q <= da_s;
                    `PSG_REG_ENV_SHAPE: begin
                        env_shape_q <= da_s[3:0];
                        env_restart_q <= 1'b1;
                    end
                    `PSG_REG_PORT_A: port_a_q <= da_s;
                    `PSG_REG_PORT_B: port_b_q <= da_s;
                    default: env_restart_q <= 1'b0;
                endcase
            end
        end
    end

    // Tone divider registers live outside; pass their writes on
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            tone_wr_out <= 1'b0;
            tone_addr_out <= 4'h0;
            tone_data_out <= `PSG_RESET_BYTE;
        end else begin
            tone_wr_out <= wr_go && (addr_q <= `PSG_REG_TONE_LAST);
            if (wr_go) begin
                tone_addr_out <= addr_q;
                tone_data_out <= da_s;
            end
        end
    end

    // Read path: plain mux, no side effect on any sound state
    reg [7:0] rd_d;

    always @* begin
        rd_d = 8'h00;
        case (addr_q)
            `PSG_REG_NOISE_PERIOD: rd_d = {3'h0, noise_period_q};
            `PSG_REG_MIXER: rd_d = mixer_q;
            `PSG_REG_VOL_A: rd_d = {3'h0, vol_a_q};
            `PSG_REG_VOL_B: rd_d = {3'h0, vol_b_q};
            `PSG_REG_VOL_C: rd_d = {3'h0, vol_c_q};
            `PSG_REG_ENV_FINE: rd_d = env_fine_q;
            `PSG_REG_ENV_COARSE: rd_d = env_coarse_q;
            `PSG_REG_ENV_SHAPE: rd_d = {4'h0, env_shape_q};
            // An input port reads its pins, an output port its latch
            `PSG_REG_PORT_A:
                rd_d = mixer_q[`PSG_MIX_DIR_A] ? port_a_q : port_a_s;
            `PSG_REG_PORT_B:
                rd_d = mixer_q[`PSG_MIX_DIR_B] ? port_b_q : port_b_s;
            default: rd_d = 8'h00;
        endcase
    end

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            da_out <= 8'h00;
            da_oe_out <= 1'b0;
        end else begin
            da_out <= rd_d;
            da_oe_out <= (mode == `PSG_MODE_READ) && sel_q;
        end
    end

    // Port pins
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            port_a_out <= 8'h00;
            port_b_out <= 8'h00;
            port_a_oe_out <= 8'h00;
            port_b_oe_out <= 8'h00;
        end else begin
            port_a_out <= port_a_q;
            port_b_out <= port_b_q;
            port_a_oe_out <= {8{mixer_q[`PSG_MIX_DIR_A]}};
            port_b_oe_out <= {8{mixer_q[`PSG_MIX_DIR_B]}};
        end
    end

    // Noise generator
    reg [3:0] npre_q;
    reg [4:0] ncnt_q;
    reg [16:0] lfsr_q;
    wire npre_tick;
    wire [4:0] nlim;
    wire nstep;

    // A period of zero runs as one
    assign nlim = (noise_period_q == 5'h00) ? 5'h01 : noise_period_q;
    assign npre_tick = (npre_q == `PSG_NOISE_PRE_MAX);
    assign nstep = npre_tick && (ncnt_q >= nlim - 5'h01);

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            npre_q <= 4'h0;
            ncnt_q <= 5'h00;
            lfsr_q <= `PSG_LFSR_SEED;
        end else begin
            npre_q <= npre_q + 4'h1;
            if (npre_tick) begin
                ncnt_q <= nstep ? 5'h00 : ncnt_q + 5'h01;
            end
            if (nstep) begin
                lfsr_q <= {lfsr_q[0] ^ lfsr_q[`PSG_LFSR_TAP],
                           lfsr_q[16:1]};
            end
        end
    end

    // Envelope generator shared by all channels
    wire [4:0] env_level;

    psg_env u_env (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .period_in({env_coarse_q, env_fine_q}),
        .shape_in(env_shape_q),
        .restart_in(env_restart_q),
        .level_out(env_level)
    );

    // Channel levels
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            chan_a_level_out <= 5'h00;
            chan_b_level_out <= 5'h00;
            chan_c_level_out <= 5'h00;
        end else begin
            chan_a_level_out <= psg_chan(tone_a_in, lfsr_q[0],
                mixer_q[`PSG_MIX_TONE_A], mixer_q[`PSG_MIX_NOISE_A],
                vol_a_q, env_level);
            chan_b_level_out <= psg_chan(tone_b_in, lfsr_q[0],
                mixer_q[`PSG_MIX_TONE_B], mixer_q[`PSG_MIX_NOISE_B],
                vol_b_q, env_level);
            chan_c_level_out <= psg_chan(tone_c_in, lfsr_q[0],
                mixer_q[`PSG_MIX_TONE_C], mixer_q[`PSG_MIX_NOISE_C],
                vol_c_q, env_level);
        end
    end

endmodule // psg_core
`default_nettype wire

// ===== verification/psg_core_props.sv
// Bus and port assertions for the sound core
`timescale 1ns/100ps
`default_nettype none

module psg_core_props (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Bus control pins
    input wire logic bdir_in,
    input wire logic bc2_in,
    input wire logic bc1_in,
    // Core outputs
    input wire logic da_oe_out,
    input wire logic [7:0] port_a_out,
    input wire logic [7:0] port_a_oe_out,
    input wire logic [7:0] port_b_out,
    input wire logic [7:0] port_b_oe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    wire logic rd_pins = {bdir_in, bc2_in, bc1_in} == 3'b011;
    wire logic wr_pins = {bdir_in, bc2_in, bc1_in} == 3'b110;
    // Cycles since write mode was last seen on the pins
    logic [3:0] wr_age_q;

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            wr_age_q <= 4'hf;
        end else if (wr_pins) begin
            wr_age_q <= 4'h0;
        end else if (wr_age_q != 4'hf) begin
            wr_age_q <= wr_age_q + 4'h1;
        end
    end

    a_oe_read_only: assert property (da_oe_out |-> $past(rd_pins, 3))
        else $error("data bus driven outside read mode");
    a_oe_rise_entry: assert property ($rose(da_oe_out) |->
        $past(rd_pins, 3) && !$past(rd_pins, 4))
        else $error("read drive not three cycles after entry");
    a_oe_drop_exit: assert property ($fell(da_oe_out) |->
        !$past(rd_pins, 3))
        else $error("read drive dropped while still reading");
    a_dir_a_uniform: assert property (port_a_oe_out == {8{port_a_oe_out[0]}})
        else $error("port a enables disagree");
    a_dir_b_uniform: assert property (port_b_oe_out == {8{port_b_oe_out[0]}})
        else $error("port b enables disagree");
    a_dir_by_write: assert property ($changed({port_a_oe_out, port_b_oe_out})
        |-> wr_age_q < 4'h5)
        else $error("port direction changed without a write");
    a_port_by_write: assert property ($changed({port_a_out, port_b_out})
        |-> wr_age_q < 4'h5)
        else $error("port data changed without a write");
    a_reset_clears: assert property (disable iff (1'b0) !reset_n_in |=>
        !da_oe_out && {port_a_out, port_b_out, port_a_oe_out} == 24'h000000)
        else $error("outputs not cleared by reset");

    c_read: cover property ($rose(da_oe_out));
    c_port_out: cover property ($rose(port_a_oe_out[0]));
    c_port_data: cover property ($changed(port_b_out));
endmodule // psg_core_props

bind psg_core psg_core_props i_psg_core_props (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .bdir_in(bdir_in),
    .bc2_in(bc2_in),
    .bc1_in(bc1_in),
    .da_oe_out(da_oe_out),
    .port_a_out(port_a_out),
    .port_a_oe_out(port_a_oe_out),
    .port_b_out(port_b_out),
    .port_b_oe_out(port_b_oe_out)
);
`default_nettype wire

// ===== verification/psg_host.sv
// Host processor model driving the parallel register bus
`timescale 1ns/100ps
`default_nettype none

module psg_host (
    // Clock
    input wire logic clk_in,
    // Data bus as seen from the core
    input wire logic [7:0] core_da_in,
    input wire logic core_oe_in,
    output logic [7:0] da_out,
    // Bus mode as {bdir, bc2, bc1} and upper address
    output logic [2:0] mode_out,
    output logic a8_out
);
    logic host_oe = 1'b0;
    logic [7:0] host_d = 8'h00;

    initial mode_out = 3'b000;
    initial a8_out = 1'b1;
    // Released bus shows the inverse of the last byte, never a stale copy
    assign da_out = core_oe_in ? core_da_in : host_oe ? host_d : ~host_d;

    // Every phase lasts four edges, above the three the core needs
    task automatic bus(input logic [2:0] m, input logic [7:0] d,
                       input logic oe);
        mode_out = m;
        host_d = d;
        host_oe = oe;
        repeat (4) @(posedge clk_in);
        #1;
    endtask

    task automatic write_reg(input logic [3:0] a, input logic [7:0] d,
                             input logic cs);
        a8_out = cs;
        bus(3'b001, {4'h0, a}, 1'b1);
        a8_out = 1'b1;
        bus(3'b110, d, 1'b1);
        bus(3'b000, d, 1'b0);
    endtask

    task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
        int i;
        d = 8'hxx;
        bus(3'b001, {4'h0, a}, 1'b1);
        mode_out = 3'b011;
        host_oe = 1'b0;
        for (i = 0; i < 8; i++) begin
            @(posedge clk_in);
            if (core_oe_in === 1'b1) begin
                d = core_da_in;
                break;
            end
        end
        #1;
        bus(3'b000, host_d, 1'b0);
    endtask
endmodule // psg_host
`default_nettype wire

// ===== verification/psg_core_tb.sv
// Self-checking bench for the sound core
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("Error at %0t: got %h expected %h", $time, g, e); \
    end \
end

module psg_core_tb;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic tone_a_in = 1'b0;
    logic [7:0] port_a_in = 8'h3c;
    logic [7:0] port_b_in = 8'hc3;
    logic [2:0] mode;
    logic a8, da_oe;
    logic [7:0] da_bus, da_core, rd, pa_out, pa_oe, pb_out, pb_oe;
    logic [4:0] lvl_a, lvl_b, lvl_c;
    logic t_wr;
    logic [3:0] t_addr;
    logic [7:0] t_data;
    int t_wr_n = 0;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    int i, n;

    always #50 clk_in = ~clk_in;

    psg_core i_psg_core (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .bdir_in(mode[2]),
        .bc2_in(mode[1]),
        .bc1_in(mode[0]),
        .a9_n_in(1'b0),
        .a8_in(a8),
        .da_in(da_bus),
        .da_out(da_core),
        .da_oe_out(da_oe),
        .port_a_in(port_a_in),
        .port_a_out(pa_out),
        .port_a_oe_out(pa_oe),
        .port_b_in(port_b_in),
        .port_b_out(pb_out),
        .port_b_oe_out(pb_oe),
        .tone_a_in(tone_a_in),
        .tone_b_in(tone_a_in),
        .tone_c_in(tone_a_in),
        .tone_wr_out(t_wr),
        .tone_addr_out(t_addr),
        .tone_data_out(t_data),
        .chan_a_level_out(lvl_a),
        .chan_b_level_out(lvl_b),
        .chan_c_level_out(lvl_c)
    );

    psg_host i_psg_host (
        .clk_in(clk_in),
        .core_da_in(da_core),
        .core_oe_in(da_oe),
        .da_out(da_bus),
        .mode_out(mode),
        .a8_out(a8)
    );

    task automatic report_and_stop;
        $display("Checks: %0d, mismatches: %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (t_wr === 1'b1) t_wr_n++;
        if (cycles == 60000) begin
            error_cnt++;
            $display("Error at %0t: run did not finish", $time);
            report_and_stop();
        end
    end

    task automatic step(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_psg_host.write_reg(a, d, 1'b1);
    endtask

    task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
        i_psg_host.read_reg(a, rd);
        `CHK(rd, e)
    endtask

    // Cycles between two successive changes of channel A's level
    task automatic gap(output int g);
        logic [4:0] v;
        int k;
        v = lvl_a;
        k = 0;
        while (lvl_a === v && k < 3000) begin
            @(posedge clk_in);
            k++;
        end
        v = lvl_a;
        g = 0;
        while (lvl_a === v && g < 3000) begin
            @(posedge clk_in);
            g++;
        end
        #1;
    endtask

    function automatic logic [7:0] fmask(input int a);
        case (a)
            6, 8, 9, 10: fmask = 8'h1f;
            13: fmask = 8'h0f;
            default: fmask = 8'hff;
        endcase
    endfunction

    initial begin
        step(10);
        reset_n_in = 1'b1;
        step(2);
        for (i = 6; i < 14; i++) chk_rd(i[3:0], 8'h00);
        chk_rd(4'he, 8'h3c);
        for (i = 6; i < 14; i++) begin
            wr(i[3:0], 8'hf0 ^ i[7:0]);
            chk_rd(i[3:0], (8'hf0 ^ i[7:0]) & fmask(i));
        end
        wr(4'h3, 8'h5c);
        `CHK({t_addr, t_data}, 12'h35c)
        `CHK(t_wr_n, 1)
        chk_rd(4'h3, 8'h00);
        wr(4'h7, 8'hc0);
        wr(4'he, 8'ha5);
        wr(4'hf, 8'h5a);
        `CHK({pa_oe, pb_oe}, 16'hffff)
        `CHK({pa_out, pb_out}, 16'ha55a)
        chk_rd(4'he, 8'ha5);
        wr(4'h7, 8'h40);
        `CHK({pa_oe, pb_oe}, 16'hff00)
        chk_rd(4'hf, 8'hc3);
        // The other two address codes must select as well
        i_psg_host.bus(3'b100, 8'h0e, 1'b1);
        i_psg_host.bus(3'b110, 8'h77, 1'b1);
        i_psg_host.bus(3'b000, 8'h77, 1'b0);
        i_psg_host.bus(3'b111, 8'h0f, 1'b1);
        i_psg_host.bus(3'b110, 8'h88, 1'b1);
        i_psg_host.bus(3'b000, 8'h88, 1'b0);
        `CHK({pa_out, pb_out}, 16'h7788)
        i_psg_host.write_reg(4'h7, 8'h00, 1'b0);
        chk_rd(4'h7, 8'h40);
        wr(4'h7, 8'h3e);
        wr(4'h8, 8'h0a);
        tone_a_in = 1'b1;
        step(4);
        `CHK(lvl_a, 5'h15)
        `CHK({lvl_b, lvl_c}, 10'h000)
        tone_a_in = 1'b0;
        step(4);
        `CHK(lvl_a, 5'h00)
        tone_a_in = 1'b1;
        wr(4'h8, 8'h0f);
        `CHK(lvl_a, 5'h1f)
        wr(4'h7, 8'h3f);
        `CHK(lvl_a, 5'h00)
        wr(4'h6, 8'h03);
        wr(4'h7, 8'h36);
        gap(n);
        `CHK(n % 48, 0)
        gap(n);
        `CHK(n % 48, 0)
        wr(4'h7, 8'h3e);
        wr(4'h8, 8'h10);
        wr(4'hb, 8'h02);
        wr(4'hc, 8'h00);
        wr(4'hd, 8'h0c);
        gap(n);
        `CHK(n, 16)
        wr(4'hb, 8'h00);
        wr(4'hc, 8'h01);
        wr(4'hd, 8'h0c);
        gap(n);
        `CHK(n, 2048)
        wr(4'hb, 8'h04);
        wr(4'hc, 8'h00);
        for (i = 0; i < 16; i++) begin
            wr(4'hd, i[7:0]);
            `CHK(lvl_a, i[2] ? 5'h00 : 5'h1f)
            step(1100);
            if (!i[3] || i[0])
                `CHK(lvl_a, (i[3] && (i[2] ^ i[1])) ? 5'h1f : 5'h00)
        end
        wr(4'h8, 8'h0a);
        `CHK(lvl_a, 5'h15)
        report_and_stop();
    end
endmodule // psg_core_tb
`default_nettype wire
